// ---- common/hsi_pkg.sv ----
// constants, register map and field layout of the high-speed input capture block
`default_nettype none
package hsi_pkg;
  localparam int CLK_MHZ = 250;
  localparam int US_CYCLES = CLK_MHZ;
  localparam int OP_CYCLE_US = 1000;
  localparam int DI_ACC_US = 30;
  localparam int ACC_04_US = 69;
  localparam int ACC_06_US = 133;
  localparam int ACC_10_US = 261;
  localparam logic signed [31:0] COMP_MIN = -32'sd5000000;
  localparam logic signed [31:0] COMP_MAX = 32'sd5000000;
  localparam int NUM_ENTRIES = 32;
  localparam int DI_N = 4;
  localparam int HOME_N = 8;
  localparam int TRK_N = 3;
  localparam int NUM_SRC = DI_N + HOME_N + TRK_N;
  localparam int ADDR_W = 10;
  // register byte offsets
  localparam logic [9:0] OFS_CTRL = 10'h000;
  localparam logic [9:0] OFS_EXT_BASE = 10'h004;
  localparam logic [9:0] OFS_STATUS = 10'h008;
  localparam logic [9:0] OFS_MARK_MON = 10'h00c;
  localparam logic [9:0] OFS_MARK_STAT = 10'h010;
  localparam logic [9:0] OFS_NOW_US = 10'h014;
  localparam logic [1:0] PAGE_CFG = 2'h1;
  localparam logic [1:0] PAGE_COMP = 2'h2;
  localparam logic [1:0] PAGE_EVT = 2'h3;
  // control fields
  localparam int CTRL_SYNC = 0;
  localparam int CTRL_ENC = 1;
  localparam int CTRL_MMON = 2;
  localparam int CTRL_MSTAT = 3;
  localparam int CTRL_RESP = 4;
  localparam logic [5:0] CTRL_RST = 6'h00;
  // entry configuration fields
  localparam int CFG_SRC = 0;
  localparam int CFG_TRAIL = 4;
  localparam int CFG_VF_USED = 5;
  localparam int CFG_VF = 6;
  localparam int CFG_ST_USED = 7;
  localparam int CFG_INDIR = 8;
  localparam int CFG_ACT = 9;
  localparam logic [11:0] CFG_RST = 12'h000;
  // actions a request times
  localparam logic [2:0] ACT_CL_ON = 3'h1;
  localparam logic [2:0] ACT_CL_OFF = 3'h2;
  localparam logic [2:0] ACT_CNT_EN = 3'h3;
  localparam logic [2:0] ACT_CNT_DIS = 3'h4;
  localparam logic [2:0] ACT_VAL_CHG = 3'h5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : hsi_pkg
`default_nettype wire

// ---- rtl/hsi_capture.sv ----
// high-speed input request capture with timing compensation and mark monitors
//
// Function
// - the mark current value monitor takes the present mark data each operation cycle when enabled.
// - the mark signal level is copied to its status bit each operation cycle when enabled.
// - up to 32 entries exist, each with source, compensation, optional valid flag and status.
// - compensation in microseconds is clamped to -5000000..5000000.
// - positive compensation moves the event earlier (late input), negative moves it later.
// - entry status shows the raw input level, untouched by compensation.
// - builtin inputs 1 to 4 are sources, sampled every 30 us on a chosen edge.
// - sources on modules flagged as extension base are rejected.
// - module inputs are sampled every 69, 133 or 261 us by the response setting.
// - indirect compensation is re-read once per operation cycle.
// - a request times clutch on/off, counter enable/disable or value change.
// - a request acts only while its valid flag is set, or always when no flag is used.
// - a request arriving while its control is inactive clears the valid flag.
`timescale 1ns/1ps
`default_nettype none
module hsi_capture
  import hsi_pkg::*;
#(
  parameter int OP_CYCLE_CYC = OP_CYCLE_US * US_CYCLES,
  parameter int NUM_ENT = NUM_ENTRIES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [DI_N-1:0] builtin_digital_input,
  input wire logic [HOME_N-1:0] home_input_a,
  input wire logic [TRK_N-1:0] tracking_enable_input,
  input wire logic mark_signal,
  input wire logic [31:0] mark_data,
  output logic [31:0] mark_monitor,
  output logic mark_status,
  output logic op_tick,
  output logic clutch_engage,
  output logic clutch_disengage,
  output logic enc_count_enable,
  output logic enc_count_disable,
  output logic enc_value_change,
  output logic [31:0] event_time_us
);

  if (NUM_ENT < 1 || NUM_ENT > 32) begin : g_chk_ent
    $error("NUM_ENT must be 1 to 32");
  end
  if (OP_CYCLE_CYC < 2) begin : g_chk_op
    $error("OP_CYCLE_CYC must be at least 2");
  end

  function automatic logic signed [31:0] clamp_comp(input logic signed [31:0] v);
    if (v < COMP_MIN) begin
      return COMP_MIN;
    end
    if (v > COMP_MAX) begin
      return COMP_MAX;
    end
    return v;
  endfunction : clamp_comp

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave

  logic aw_held_q, w_held_q;
  logic [ADDR_W-1:0] awaddr_q, araddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;

  wire wr_go = aw_held_q && w_held_q && !bvalid_q;
  wire [1:0] wr_page = awaddr_q[9:8];
  wire [4:0] wr_idx = awaddr_q[6:2];
  wire wr_ent_ok = (awaddr_q[7] == 1'b0) && (32'(wr_idx) < NUM_ENT);
  wire wr_ctrl = wr_go && awaddr_q == OFS_CTRL;
  wire wr_ext = wr_go && awaddr_q == OFS_EXT_BASE;
  wire wr_cfg = wr_go && wr_page == PAGE_CFG && wr_ent_ok;
  wire wr_comp = wr_go && wr_page == PAGE_COMP && wr_ent_ok;
  wire wr_hit = wr_ctrl || wr_ext || wr_cfg || wr_comp;

  assign s_axi_awready = !aw_held_q;
  assign s_axi_wready = !w_held_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_held_q) begin
        aw_held_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_q) begin
        w_held_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // time base, sampling and input synchronisers

  logic [NUM_SRC-1:0] src_m_q, src_s_q, smp_q, prev_q;
  logic mark_m_q, mark_s_q;
  logic [7:0] us_div_q;
  logic [31:0] now_us_q, op_cnt_q;
  logic [8:0] di_cnt_q, mod_cnt_q;
  logic [5:0] ctrl_q;
  logic [NUM_SRC-1:0] ext_q;

  wire [NUM_SRC-1:0] src_raw = {tracking_enable_input, home_input_a, builtin_digital_input};
  wire us_tick = us_div_q == 8'(US_CYCLES - 1);
  wire [1:0] resp_sel = ctrl_q[CTRL_RESP +: 2];
  wire [8:0] mod_acc = resp_sel == 2'h0 ? 9'(ACC_04_US) :
                       resp_sel == 2'h1 ? 9'(ACC_06_US) : 9'(ACC_10_US);
  wire di_smp = us_tick && di_cnt_q == 9'(DI_ACC_US - 1);
  wire mod_smp = us_tick && mod_cnt_q >= mod_acc - 9'h001;
  wire [NUM_SRC-1:0] edge_r = smp_q & ~prev_q;
  wire [NUM_SRC-1:0] edge_f = ~smp_q & prev_q;

  assign op_tick = op_cnt_q == 32'(OP_CYCLE_CYC - 1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_m_q <= '0;
      src_s_q <= '0;
      smp_q <= '0;
      prev_q <= '0;
      mark_m_q <= 1'b0;
      mark_s_q <= 1'b0;
      us_div_q <= 8'h00;
      now_us_q <= 32'h0000_0000;
      op_cnt_q <= 32'h0000_0000;
      di_cnt_q <= 9'h000;
      mod_cnt_q <= 9'h000;
    end else begin
      src_m_q <= src_raw;
      src_s_q <= src_m_q;
      mark_m_q <= mark_signal;
      mark_s_q <= mark_m_q;
      prev_q <= smp_q;
      if (di_smp) begin
        smp_q[DI_N-1:0] <= src_s_q[DI_N-1:0];
      end
      if (mod_smp) begin
        smp_q[NUM_SRC-1:DI_N] <= src_s_q[NUM_SRC-1:DI_N];
      end
      us_div_q <= us_tick ? 8'h00 : us_div_q + 8'h01;
      op_cnt_q <= op_tick ? 32'h0000_0000 : op_cnt_q + 32'h0000_0001;
      if (us_tick) begin
        now_us_q <= now_us_q + 32'h0000_0001;
        di_cnt_q <= di_smp ? 9'h000 : di_cnt_q + 9'h001;
        mod_cnt_q <= mod_smp ? 9'h000 : mod_cnt_q + 9'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // request entries

  logic [11:0] cfg_q [NUM_ENT];
  logic signed [31:0] comp_q [NUM_ENT];
  logic signed [31:0] comp_eff_q [NUM_ENT];
  logic [31:0] evt_q [NUM_ENT];
  logic [31:0] status_q;
  logic [NUM_ENT-1:0] fire, clr_vf;
  logic [5:1] act_hit;

  wire [31:0] ctrl_wr = merge(32'(ctrl_q), wdata_q, wstrb_q);
  wire [31:0] ext_wr = merge(32'(ext_q), wdata_q, wstrb_q);
  wire [31:0] cfg_wr = merge(32'(cfg_q[wr_idx]), wdata_q, wstrb_q);

  always_comb begin
    fire = '0;
    clr_vf = '0;
    act_hit = 5'h00;
    for (int i = 0; i < NUM_ENT; i++) begin
      logic [3:0] s;
      logic [2:0] a;
      logic hit, ok, act;
      s = cfg_q[i][CFG_SRC +: 4];
      a = cfg_q[i][CFG_ACT +: 3];
      // an entry with no action is unregistered: it neither fires nor clears its flag
      hit = a != 3'h0 && a <= ACT_VAL_CHG && 32'(s) < NUM_SRC
            && (cfg_q[i][CFG_TRAIL] ? edge_f[s] : edge_r[s]);
      ok = 32'(s) < DI_N || !ext_q[s];
      act = (a == ACT_CL_ON || a == ACT_CL_OFF) ? ctrl_q[CTRL_SYNC] : ctrl_q[CTRL_ENC];
      if (hit && ok && !act) begin
        clr_vf[i] = 1'b1;
      end
      if (hit && ok && act && (!cfg_q[i][CFG_VF_USED] || cfg_q[i][CFG_VF])) begin
        fire[i] = 1'b1;
        if (a != 3'h0 && a <= ACT_VAL_CHG) begin
          act_hit[a] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= CTRL_RST;
      ext_q <= '0;
      status_q <= 32'h0000_0000;
      for (int i = 0; i < NUM_ENT; i++) begin
        cfg_q[i] <= CFG_RST;
        comp_q[i] <= 32'sh0000_0000;
        comp_eff_q[i] <= 32'sh0000_0000;
        evt_q[i] <= 32'h0000_0000;
      end
    end else begin
      if (wr_ctrl) begin
        ctrl_q <= ctrl_wr[5:0];
      end
      if (wr_ext) begin
        ext_q <= ext_wr[NUM_SRC-1:0];
      end
      for (int i = 0; i < NUM_ENT; i++) begin
        logic [11:0] nc;
        nc = (wr_cfg && 32'(wr_idx) == i) ? cfg_wr[11:0] : cfg_q[i];
        // a software set in the same cycle beats the hardware clear
        if (clr_vf[i] && !(wr_cfg && 32'(wr_idx) == i && nc[CFG_VF])) begin
          nc[CFG_VF] = 1'b0;
        end
        cfg_q[i] <= nc;
        if (wr_comp && 32'(wr_idx) == i) begin
          comp_q[i] <= merge(comp_q[i], wdata_q, wstrb_q);
          if (!cfg_q[i][CFG_INDIR]) begin
            comp_eff_q[i] <= clamp_comp(merge(comp_q[i], wdata_q, wstrb_q));
          end
        end else if (op_tick && cfg_q[i][CFG_INDIR]) begin
          comp_eff_q[i] <= clamp_comp(comp_q[i]);
        end
        if (fire[i]) begin
          // late input means the real event lies earlier than the stamp
          evt_q[i] <= now_us_q - comp_eff_q[i];
        end
        if (op_tick && cfg_q[i][CFG_ST_USED]) begin
          status_q[i] <= src_s_q[cfg_q[i][CFG_SRC +: 4]];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // action pulses and mark monitors

  logic [4:0] act_q;
  logic [31:0] evt_out_q, mark_mon_q;
  logic mark_st_q;
  logic [31:0] fire_time;

  always_comb begin
    fire_time = evt_out_q;
    for (int i = NUM_ENT - 1; i >= 0; i--) begin
      if (fire[i]) begin
        fire_time = now_us_q - comp_eff_q[i];
      end
    end
  end

  assign clutch_engage = act_q[0];
  assign clutch_disengage = act_q[1];
  assign enc_count_enable = act_q[2];
  assign enc_count_disable = act_q[3];
  assign enc_value_change = act_q[4];
  assign event_time_us = evt_out_q;
  assign mark_monitor = mark_mon_q;
  assign mark_status = mark_st_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_q <= 5'h00;
      evt_out_q <= 32'h0000_0000;
      mark_mon_q <= 32'h0000_0000;
      mark_st_q <= 1'b0;
    end else begin
      act_q <= act_hit;
      evt_out_q <= fire_time;
      if (op_tick && ctrl_q[CTRL_MMON]) begin
        mark_mon_q <= mark_data;
      end
      if (op_tick && ctrl_q[CTRL_MSTAT]) begin
        mark_st_q <= mark_s_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read path

  wire [1:0] rd_page = s_axi_araddr[9:8];
  wire [4:0] rd_idx = s_axi_araddr[6:2];
  wire rd_ent_ok = s_axi_araddr[7] == 1'b0 && 32'(rd_idx) < NUM_ENT;
  logic [31:0] rd_val;
  logic rd_ok;

  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    if (rd_page != 2'h0) begin
      rd_ok = rd_ent_ok;
      if (rd_ent_ok) begin
        rd_val = rd_page == PAGE_CFG ? 32'(cfg_q[rd_idx]) :
                 rd_page == PAGE_COMP ? comp_q[rd_idx] : evt_q[rd_idx];
      end
    end else begin
      case (s_axi_araddr)
        OFS_CTRL: rd_val = 32'(ctrl_q);
        OFS_EXT_BASE: rd_val = 32'(ext_q);
        OFS_STATUS: rd_val = status_q;
        OFS_MARK_MON: rd_val = mark_mon_q;
        OFS_MARK_STAT: rd_val = 32'(mark_st_q);
        OFS_NOW_US: rd_val = now_us_q;
        default: rd_ok = 1'b0;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_val;
      rresp_q <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule : hsi_capture
`default_nettype wire

// ---- verif/hsi_sensor_model.sv ----
// sensor model: drives the capture input pins after a programmable lag
`timescale 1ns/1ps
`default_nettype none
module hsi_sensor_model (
  input wire logic aclk,
  input wire logic [14:0] lvl,
  input wire logic [7:0] lag,
  output logic [3:0] di_pin,
  output logic [7:0] home_pin,
  output logic [2:0] trk_pin
);
  logic [7:0] cnt_q = 8'h00;
  logic [14:0] out_q = 15'h0000;
  // a slow sensor holds its old level for lag cycles before switching
  always_ff @(posedge aclk) begin
    if (lvl == out_q) cnt_q <= 8'h00;
    else if (cnt_q >= lag) out_q <= lvl;
    else cnt_q <= cnt_q + 8'h01;
  end
  assign di_pin = out_q[3:0];
  assign home_pin = out_q[11:4];
  assign trk_pin = out_q[14:12];
endmodule : hsi_sensor_model
`default_nettype wire

// ---- verif/hsi_capture_sva.sv ----
// assertion checker on the capture block ports
`timescale 1ns/1ps
`default_nettype none
module hsi_capture_chk #(
  parameter int OP_CYCLE_CYC = 50
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] mark_data,
  input wire logic [31:0] mark_monitor,
  input wire logic mark_status,
  input wire logic op_tick,
  input wire logic clutch_engage,
  input wire logic clutch_disengage,
  input wire logic enc_count_enable,
  input wire logic enc_count_disable,
  input wire logic enc_value_change,
  input wire logic [31:0] event_time_us
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [31:0] tick_cnt_q;
  logic tick_seen_q;
  wire logic any_pulse = clutch_engage | clutch_disengage | enc_count_enable
    | enc_count_disable | enc_value_change;
  // the first tick after reset has no reference and is not timed
  always_ff @(posedge aclk) begin
    if (!aresetn || op_tick) tick_cnt_q <= 32'h0;
    else tick_cnt_q <= tick_cnt_q + 32'h1;
    if (!aresetn) tick_seen_q <= 1'b0;
    else if (op_tick) tick_seen_q <= 1'b1;
  end
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_mmon;
    $changed(mark_monitor) |-> $past(op_tick) && mark_monitor == $past(mark_data);
  endproperty
  a_mmon: assert property (p_mmon) else $error("monitor moved off tick");
  property p_mstat;
    $changed(mark_status) |-> $past(op_tick);
  endproperty
  a_mstat: assert property (p_mstat) else $error("mark status moved off tick");
  property p_tick;
    op_tick && tick_seen_q |-> tick_cnt_q == OP_CYCLE_CYC - 1;
  endproperty
  a_tick: assert property (p_tick) else $error("operation cycle length wrong");
  property p_evt;
    $changed(event_time_us) |-> any_pulse;
  endproperty
  a_evt: assert property (p_evt) else $error("event time moved without event");
  property p_ce;
    clutch_engage |=> !clutch_engage;
  endproperty
  a_ce: assert property (p_ce) else $error("engage pulse too long");
  property p_vc;
    enc_value_change |=> !enc_value_change;
  endproperty
  a_vc: assert property (p_vc) else $error("value change pulse too long");
  property p_wr;
    s_wr_taken |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_wr: assert property (p_wr) else $error("write response missing");
  property p_rd;
    s_rd_taken |=> s_axi_rvalid;
  endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
endmodule : hsi_capture_chk
bind hsi_capture hsi_capture_chk #(.OP_CYCLE_CYC(OP_CYCLE_CYC)) u_chk (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .mark_data, .mark_monitor, .mark_status,
  .op_tick, .clutch_engage, .clutch_disengage, .enc_count_enable, .enc_count_disable,
  .enc_value_change, .event_time_us);
`default_nettype wire

// ---- verif/hsi_capture_tb.sv ----
// self-checking testbench of the capture block
`timescale 1ns/1ps
`default_nettype none
module hsi_capture_tb;
  import hsi_pkg::*;
  localparam int OPC = 50;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [9:0] s_axi_awaddr = 10'h000;
  logic [9:0] s_axi_araddr = 10'h000;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic mark_signal = 1'b0;
  logic [31:0] mark_data = 32'h0;
  logic [14:0] lvl = 15'h0000;
  logic [7:0] lag = 8'h00;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, mark_status;
  logic op_tick, clutch_engage, clutch_disengage, enc_count_enable, enc_count_disable;
  logic enc_value_change;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, mark_monitor, event_time_us, d, md, now;
  logic [3:0] builtin_digital_input;
  logic [7:0] home_input_a;
  logic [2:0] tracking_enable_input;
  logic [4:0] p;
  int err_total = 0;
  int n_tests = 0;
  int e, s, c;
  int ctab[5] = '{6000000, -7000000, 0, 5000000, 0};
  wire logic [4:0] pv = {enc_value_change, enc_count_disable, enc_count_enable,
    clutch_disengage, clutch_engage};
  hsi_capture #(.OP_CYCLE_CYC(OPC)) dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .builtin_digital_input,
    .home_input_a, .tracking_enable_input, .mark_signal, .mark_data, .mark_monitor,
    .mark_status, .op_tick, .clutch_engage, .clutch_disengage, .enc_count_enable,
    .enc_count_disable, .enc_value_change, .event_time_us);
  hsi_sensor_model u_sens (.aclk, .lvl, .lag, .di_pin(builtin_digital_input),
    .home_pin(home_input_a), .trk_pin(tracking_enable_input));
  initial begin
    forever #2 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////////////////////
  function automatic int clampc(int v);
    return v < COMP_MIN ? COMP_MIN : (v > COMP_MAX ? COMP_MAX : v);
  endfunction : clampc
  function automatic logic [31:0] mk_cfg(int sr, int t, int u, int v, int a);
    return 32'(sr | t << CFG_TRAIL | u << CFG_VF_USED | v << CFG_VF | 1 << CFG_ST_USED
      | a << CFG_ACT);
  endfunction : mk_cfg
  task automatic chk_val(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk_val
  task automatic chk_resp(input logic [1:0] g, input logic [1:0] x);
    n_tests++;
    if (g !== x) begin
      err_total++;
      $display("wrong value at %0t: response %h expected %h", $time, g, x);
    end
  endtask : chk_resp
  task automatic wr(input logic [9:0] a, input logic [31:0] v, output logic [1:0] rs);
    int i;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 200; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
    if (i == 200) err_total++;
  endtask : wr
  task automatic rd(input logic [9:0] a, output logic [31:0] v, output logic [1:0] rs);
    int i;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 200; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        v = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
    if (i == 200) err_total++;
  endtask : rd
  // toggles one sensor, then watches the action pulses for up to n cycles, stopping at the first pulse
  task automatic fire(input int sr, input int n, output logic [4:0] q);
    @(posedge aclk);
    lag <= 8'($urandom_range(63));
    lvl[sr] <= ~lvl[sr];
    q = 5'h00;
    for (int i = 0; i < n && q === 5'h00; i++) begin
      @(negedge aclk);
      q = pv;
    end
  endtask : fire
  task automatic complete_run;
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run
  ////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (98000) @(posedge aclk);
    err_total++;
    complete_run();
  end
  initial begin
    void'($urandom(36630));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_CTRL, d, r);
    chk_val(d, 32'h0);
    rd(10'h0f0, d, r);
    chk_resp(r, RESP_SLVERR);
    wr(OFS_STATUS, 32'h1, r);
    chk_resp(r, RESP_SLVERR);
    md = $urandom;
    mark_data <= md;
    mark_signal <= 1'b1;
    wr(OFS_CTRL, 32'h0f, r);
    repeat (3 * OPC) @(posedge aclk);
    chk_val(mark_monitor, md);
    chk_val(32'(mark_status), 32'h1);
    wr(OFS_CTRL, 32'h03, r);
    mark_data <= ~md;
    repeat (3 * OPC) @(posedge aclk);
    rd(OFS_MARK_MON, d, r);
    chk_val(d, md);
    wr(OFS_CTRL, 32'h0f, r);
    for (int k = 0; k < 5; k++) begin
      e = $urandom_range(31);
      s = $urandom_range(3);
      c = (k == 2) ? int'($urandom_range(10000000)) - 5000000 : ctab[k];
      // one entry takes its compensation indirectly: only the next tick may load it
      wr(10'h100 + 10'(e * 4), mk_cfg(s, lvl[s], 0, 0, k + 1)
        | ((k == 3) ? 32'(1 << CFG_INDIR) : 32'h0), r);
      wr(10'h200 + 10'(e * 4), 32'(c), r);
      repeat (OPC) @(posedge aclk);
      fire(s, 7800, p);
      chk_val(32'(p), 32'h1 << k);
      rd(OFS_NOW_US, now, r);
      chk_val((now - event_time_us - 32'(clampc(c))) & 32'hffff_fffe, 32'h0);
      repeat (2 * OPC) @(posedge aclk);
      rd(OFS_STATUS, d, r);
      chk_val(32'(d[e]), 32'(lvl[s]));
      wr(10'h100 + 10'(e * 4), 32'h0, r);
    end
    wr(10'h100, mk_cfg(0, lvl[0], 1, 0, 3), r);
    fire(0, 7800, p);
    chk_val(32'(p), 32'h0);
    wr(OFS_CTRL, 32'h0d, r);
    wr(10'h100, mk_cfg(0, lvl[0], 1, 1, 3), r);
    fire(0, 7800, p);
    chk_val(32'(p), 32'h0);
    rd(10'h100, d, r);
    chk_val(32'(d[CFG_VF]), 32'h0);
    wr(OFS_CTRL, 32'h0f, r);
    wr(10'h100, mk_cfg(0, lvl[0], 1, 1, 3), r);
    fire(0, 7800, p);
    chk_val(32'(p), 32'h4);
    wr(OFS_EXT_BASE, 32'h10, r);
    wr(10'h104, mk_cfg(4, lvl[4], 0, 0, 5), r);
    // a main-base source toggled alongside must still fire at the module sample rate
    wr(10'h108, mk_cfg(5, lvl[5], 0, 0, 4), r);
    lvl[5] <= ~lvl[5];
    fire(4, 17600, p);
    chk_val(32'(p), 32'h8);
    complete_run();
  end
endmodule : hsi_capture_tb
`default_nettype wire
